// ==== logic/pls_port.sv ====
// Packet link status and control port: host registers, interrupt, tx FIFO.
// Assumes host strobes arrive asynchronously; the bit engine shares core_clk.
//
// Operation
// - Latched status bit sets on its event and holds until the host writes one to it.
// - Real-time bits show the live condition; status writes leave them alone.
// - Writing one loads the latch into the read copy and clears it; zero holds.
// - Each status event is gated by the mask onto the low-active interrupt.
// - Interrupt releases once the causing latched bit is captured, or a live bit's condition ends, and nothing else pends.
// - Rising edge of the rx reset bit resets the receive engine once.
// - Rising edge of the tx reset bit resets the transmit engine once.
// - Fill select: zero sends 7Eh flags, one sends FFh idle between packets.
// - Rising abort edge flushes the tx FIFO and sends one FEh octet.
// - Host sets the last-byte mark before the final byte; hardware clears it.
// - Bit-stuff disable: zero keeps zero insertion, one turns it off.
// - Checksum disable: zero appends CRC, one omits it.
module pls_port (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic bus_cs_n,
	input wire logic bus_rd_n,
	input wire logic bus_wr_n,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe,
	output logic irq_n,
	output logic rx_engine_reset,
	output logic tx_engine_reset,
	output logic tx_abort_request,
	output logic [7:0] tx_fill_byte,
	output logic tx_last_byte_mark,
	output logic tx_bit_stuff_disable,
	output logic tx_checksum_disable,
	output logic tx_byte_valid,
	input wire logic tx_byte_ready,
	output logic [7:0] tx_byte_data,
	output logic tx_byte_last,
	input wire logic tx_last_sent,
	input wire logic tx_frame_done_evt,
	input wire logic tx_underflow_flag,
	input wire logic rx_frame_begin_evt,
	input wire logic rx_frame_finish_evt,
	input wire logic rx_fifo_over_half,
	input wire logic rx_fifo_has_data,
	input wire logic [7:0] rx_info
);
	import pls_pkg::*;

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	logic [18:0] pin_s1_reg, pin_s2_reg;
	logic cs_act, rd_act, wr_act;
	logic [7:0] addr_s, data_s;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_s1_reg <= PIN_SYNC_RESET;
			pin_s2_reg <= PIN_SYNC_RESET;
		end else begin
			pin_s1_reg <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign cs_act = !pin_s2_reg[18];
	assign rd_act = cs_act && !pin_s2_reg[17];
	assign wr_act = cs_act && !pin_s2_reg[16];
	assign addr_s = pin_s2_reg[15:8];
	assign data_s = pin_s2_reg[7:0];

	// --------------------------------------------------------------
	// Host access sequencing
	// --------------------------------------------------------------
	// A write commits when its strobe ends, so the data has settled
	pls_port_state_t state_reg, state_next;
	logic [7:0] wr_addr_reg, wr_addr_next, wr_data_reg, wr_data_next;
	logic commit;

	always_comb begin
		state_next = state_reg;
		wr_addr_next = wr_addr_reg;
		wr_data_next = wr_data_reg;
		commit = 1'b0;
		case (state_reg)
			PS_IDLE: begin
				if (wr_act)
					state_next = PS_WRITE;
				else if (rd_act)
					state_next = PS_READ;
			end
			PS_WRITE: begin
				if (wr_act) begin
					wr_addr_next = addr_s;
					wr_data_next = data_s;
				end else begin
					commit = 1'b1;
					state_next = PS_IDLE;
				end
			end
			PS_READ: begin
				if (!rd_act)
					state_next = PS_IDLE;
			end
			default: state_next = PS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= PS_IDLE;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			wr_addr_reg <= wr_addr_next;
			wr_data_reg <= wr_data_next;
		end
	end

	logic wr_ctrl, wr_status, wr_mask, wr_rx_info, wr_tx_info, wr_tx_data;
	assign wr_ctrl = commit && (wr_addr_reg == ADDR_CTRL);
	assign wr_status = commit && (wr_addr_reg == ADDR_STATUS);
	assign wr_mask = commit && (wr_addr_reg == ADDR_IRQ_MASK);
	assign wr_rx_info = commit && (wr_addr_reg == ADDR_RX_INFO);
	assign wr_tx_info = commit && (wr_addr_reg == ADDR_TX_INFO);
	assign wr_tx_data = commit && (wr_addr_reg == ADDR_TX_DATA);

	// --------------------------------------------------------------
	// Control register and its edge actions
	// --------------------------------------------------------------
	logic [7:0] ctrl_reg, ctrl_next, irq_mask_reg, irq_mask_next;
	logic rx_rst_reg, rx_rst_next, tx_rst_reg, tx_rst_next, abort_reg, abort_next;
	logic [7:0] fill_reg, fill_next;

	always_comb begin
		ctrl_next = ctrl_reg;
		// Top bit is not stored, so it reads back as zero
		if (wr_ctrl)
			ctrl_next = wr_data_reg & CTRL_WR_MASK;
		else if (tx_last_sent)
			ctrl_next[CTRL_LAST] = 1'b0;
		irq_mask_next = wr_mask ? (wr_data_reg & IRQ_MASK_WR_MASK) : irq_mask_reg;
		rx_rst_next = ctrl_next[CTRL_RX_RST] && !ctrl_reg[CTRL_RX_RST];
		tx_rst_next = ctrl_next[CTRL_TX_RST] && !ctrl_reg[CTRL_TX_RST];
		abort_next = ctrl_next[CTRL_ABORT] && !ctrl_reg[CTRL_ABORT];
		fill_next = ctrl_next[CTRL_FILL] ? FILL_IDLE : FILL_FLAG;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_reg <= CTRL_RESET;
			irq_mask_reg <= IRQ_MASK_RESET;
			rx_rst_reg <= 1'b0;
			tx_rst_reg <= 1'b0;
			abort_reg <= 1'b0;
			fill_reg <= FILL_FLAG;
		end else begin
			ctrl_reg <= ctrl_next;
			irq_mask_reg <= irq_mask_next;
			rx_rst_reg <= rx_rst_next;
			tx_rst_reg <= tx_rst_next;
			abort_reg <= abort_next;
			fill_reg <= fill_next;
		end
	end

	assign rx_engine_reset = rx_rst_reg;
	assign tx_engine_reset = tx_rst_reg;
	// Engine sends one ABORT_OCTET on this pulse, then the fill byte
	assign tx_abort_request = abort_reg;
	assign tx_fill_byte = fill_reg;
	assign tx_last_byte_mark = ctrl_reg[CTRL_LAST];
	assign tx_bit_stuff_disable = ctrl_reg[CTRL_NO_STUFF];
	assign tx_checksum_disable = ctrl_reg[CTRL_NO_CRC];

	// --------------------------------------------------------------
	// Transmit FIFO
	// --------------------------------------------------------------
	// Each word carries the last-byte mark taken at the moment of the write
	pls_fifo_if #(.W(TX_WORD_W)) txq ();

	assign txq.in_data = {ctrl_reg[CTRL_LAST], wr_data_reg};
	// A write into a full FIFO is dropped; software checks capacity first
	assign txq.in_valid = wr_tx_data;
	assign txq.flush = abort_reg || tx_rst_reg;
	assign txq.out_ready = tx_byte_ready;
	assign tx_byte_valid = txq.out_valid;
	assign tx_byte_data = txq.out_data[7:0];
	assign tx_byte_last = txq.out_data[8];

	pls_fifo #(
		.WIDTH(TX_WORD_W),
		.DEPTH(TX_FIFO_DEPTH)
	) u_tx_fifo (
		.clk(core_clk),
		.reset(reset),
		.port(txq.store)
	);

	// --------------------------------------------------------------
	// Status and information registers
	// --------------------------------------------------------------
	logic [7:0] st_evt, st_val, st_pend, rxi_val, txi_evt, txi_val;

	always_comb begin
		st_evt = STATUS_RESET;
		st_evt[ST_RX_FINISH] = rx_frame_finish_evt;
		st_evt[ST_RX_BEGIN] = rx_frame_begin_evt;
		st_evt[ST_RX_HALF] = rx_fifo_over_half;
		st_evt[ST_RX_DATA] = rx_fifo_has_data;
		st_evt[ST_TX_HALF] = txq.low_half;
		st_evt[ST_TX_ROOM] = txq.in_ready;
		st_evt[ST_TX_DONE] = tx_frame_done_evt;
		txi_evt = STATUS_RESET;
		txi_evt[TXI_UNDERFLOW] = tx_underflow_flag;
		txi_evt[TXI_DRAINED] = !txq.out_valid;
		txi_evt[TXI_FULL] = !txq.in_ready;
	end

	pls_status_bank #(
		.W(8),
		.LATCHED(STATUS_LATCHED)
	) u_status (
		.clk(core_clk),
		.reset(reset),
		.evt(st_evt),
		.wr_stb(wr_status),
		.wr_mask(wr_data_reg),
		.rd_val(st_val),
		.pend(st_pend)
	);

	pls_status_bank #(
		.W(8),
		.LATCHED(RX_INFO_LATCHED)
	) u_rx_info (
		.clk(core_clk),
		.reset(reset),
		.evt(rx_info),
		.wr_stb(wr_rx_info),
		.wr_mask(wr_data_reg),
		.rd_val(rxi_val),
		.pend()
	);

	pls_status_bank #(
		.W(8),
		.LATCHED(TX_INFO_LATCHED)
	) u_tx_info (
		.clk(core_clk),
		.reset(reset),
		.evt(txi_evt),
		.wr_stb(wr_tx_info),
		.wr_mask(wr_data_reg),
		.rd_val(txi_val),
		.pend()
	);

	// --------------------------------------------------------------
	// Interrupt
	// --------------------------------------------------------------
	// Latched sources drop only when the host captures them
	logic irq_n_reg, irq_n_next;

	always_comb begin
		irq_n_next = !(|(st_pend & irq_mask_reg));
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			irq_n_reg <= 1'b1;
		else
			irq_n_reg <= irq_n_next;
	end

	assign irq_n = irq_n_reg;

	// --------------------------------------------------------------
	// Read data
	// --------------------------------------------------------------
	logic [7:0] rdata_reg, rdata_next;

	always_comb begin
		case (addr_s)
			ADDR_CTRL: rdata_next = ctrl_reg;
			ADDR_STATUS: rdata_next = st_val;
			ADDR_IRQ_MASK: rdata_next = irq_mask_reg;
			ADDR_RX_INFO: rdata_next = rxi_val;
			ADDR_TX_INFO: rdata_next = txi_val;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign bus_data_out = rdata_reg;
	assign bus_data_oe = (state_reg == PS_READ);
endmodule

// ==== logic/pls_pkg.sv ====
// Constants shared by the packet link status and control port.
// Assumes one 125 MHz core clock and a synchronous active-high reset.
package pls_pkg;
	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'hB0;
	localparam logic [7:0] ADDR_STATUS = 8'hB1;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hB2;
	localparam logic [7:0] ADDR_RX_INFO = 8'hB3;
	localparam logic [7:0] ADDR_TX_INFO = 8'hB4;
	localparam logic [7:0] ADDR_TX_DATA = 8'hB5;

	// --------------------------------------------------------------
	// Control bit positions and reset values
	// --------------------------------------------------------------
	localparam int CTRL_RX_RST = 6;
	localparam int CTRL_FILL = 5;
	localparam int CTRL_TX_RST = 4;
	localparam int CTRL_ABORT = 3;
	localparam int CTRL_LAST = 2;
	localparam int CTRL_NO_STUFF = 1;
	localparam int CTRL_NO_CRC = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WR_MASK = 8'h7F;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_WR_MASK = 8'h7F;

	// --------------------------------------------------------------
	// Status and information layouts
	// --------------------------------------------------------------
	localparam int ST_RX_FINISH = 6;
	localparam int ST_RX_BEGIN = 5;
	localparam int ST_RX_HALF = 4;
	localparam int ST_RX_DATA = 3;
	localparam int ST_TX_HALF = 2;
	localparam int ST_TX_ROOM = 1;
	localparam int ST_TX_DONE = 0;
	localparam logic [7:0] STATUS_LATCHED = 8'h61;
	localparam logic [7:0] RX_INFO_LATCHED = 8'hF0;
	localparam logic [7:0] TX_INFO_LATCHED = 8'h04;
	localparam int TXI_UNDERFLOW = 2;
	localparam int TXI_DRAINED = 1;
	localparam int TXI_FULL = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// --------------------------------------------------------------
	// Line octets and sizes
	// --------------------------------------------------------------
	localparam logic [7:0] FILL_FLAG = 8'h7E;
	localparam logic [7:0] FILL_IDLE = 8'hFF;
	localparam logic [7:0] ABORT_OCTET = 8'hFE;
	localparam int TX_FIFO_DEPTH = 16;
	localparam int TX_WORD_W = 9;
	localparam logic [18:0] PIN_SYNC_RESET = 19'h70000;

	// --------------------------------------------------------------
	// Host access states
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_WRITE = 2'b01,
		PS_READ = 2'b10
	} pls_port_state_t;
endpackage

// ==== logic/pls_fifo_if.sv ====
// Stream interface between the port logic and its transmit FIFO.
// Assumes both ends run on the same clock.
interface pls_fifo_if #(parameter int W = 9);
	logic [W-1:0] in_data;
	logic in_valid;
	logic in_ready;
	logic [W-1:0] out_data;
	logic out_valid;
	logic out_ready;
	logic flush;
	logic low_half;

	modport store (input in_data, input in_valid, output in_ready, output out_data, output out_valid,
		input out_ready, input flush, output low_half);
	modport user (output in_data, output in_valid, input in_ready, input out_data, input out_valid,
		output out_ready, output flush, input low_half);
endinterface

// ==== logic/pls_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes a power-of-two depth and one clock.
module pls_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	pls_fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0] count_reg, count_next;
	logic push, pop;

	// Count is one bit wider than the pointers so that full differs from empty
	assign port.in_ready = (count_reg != (AW+1)'(DEPTH)) && !port.flush;
	assign port.out_valid = (count_reg != '0);
	assign port.out_data = mem[rd_ptr_reg];
	assign port.low_half = (count_reg <= (AW+1)'(DEPTH / 2));
	assign push = port.in_valid && port.in_ready;
	assign pop = port.out_valid && port.out_ready && !port.flush;

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next = count_reg;
		if (port.flush) begin
			wr_ptr_next = '0;
			rd_ptr_next = '0;
			count_next = '0;
		end else begin
			if (push)
				wr_ptr_next = wr_ptr_reg + AW'(1);
			if (pop)
				rd_ptr_next = rd_ptr_reg + AW'(1);
			count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
		end
	end

	// Storage has no reset; only pointers carry meaning
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= port.in_data;
	end
endmodule

// ==== logic/pls_status_bank.sv ====
// One status or information register: latches, read copy, live bits.
// Assumes event inputs come from logic on the same clock.
module pls_status_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] LATCHED = '0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] evt,
	input wire logic wr_stb,
	input wire logic [W-1:0] wr_mask,
	output logic [W-1:0] rd_val,
	output logic [W-1:0] pend
);
	logic [W-1:0] latch_reg, latch_next, copy_reg, copy_next, sel;

	always_comb begin
		sel = wr_stb ? wr_mask : '0;
		// Set wins over the clear of the same cycle
		latch_next = (latch_reg & ~sel) | (evt & LATCHED);
		copy_next = (copy_reg & ~sel) | (latch_reg & sel);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch_reg <= '0;
			copy_reg <= '0;
		end else begin
			latch_reg <= latch_next;
			copy_reg <= copy_next;
		end
	end

	assign rd_val = (copy_reg & LATCHED) | (evt & ~LATCHED);
	assign pend = latch_reg | (evt & ~LATCHED);
endmodule

// ==== dv/pls_port_properties.sv ====
// Checker for the packet link port, bound to its top ports.
// Assumes one core clock and a synchronous active-high reset.
module pls_port_properties
	import pls_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic bus_cs_n,
	input wire logic bus_rd_n,
	input wire logic bus_data_oe,
	input wire logic irq_n,
	input wire logic rx_engine_reset,
	input wire logic tx_engine_reset,
	input wire logic tx_abort_request,
	input wire logic [7:0] tx_fill_byte,
	input wire logic tx_last_byte_mark,
	input wire logic tx_byte_valid,
	input wire logic tx_last_sent
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// ----
	// Properties
	// ----
	AST_FILL_VALUE: assert property (tx_fill_byte == FILL_FLAG || tx_fill_byte == FILL_IDLE)
		else $error("fill byte is neither flag nor idle");
	AST_RESET_STATE: assert property ($past(reset) |-> irq_n && !bus_data_oe && tx_fill_byte == FILL_FLAG)
		else $error("outputs not at rest after reset");
	AST_RXRST_ONCE: assert property (rx_engine_reset |=> !rx_engine_reset [*3])
		else $error("rx reset pulse repeated");
	AST_TXRST_ONCE: assert property (tx_engine_reset |=> !tx_engine_reset [*3])
		else $error("tx reset pulse repeated");
	AST_ABORT_ONCE: assert property (tx_abort_request |=> !tx_abort_request [*3])
		else $error("abort pulse repeated");
	AST_ABORT_FLUSH: assert property (tx_abort_request |=> !tx_byte_valid)
		else $error("fifo not flushed by abort");
	AST_TXRST_FLUSH: assert property (tx_engine_reset |=> !tx_byte_valid)
		else $error("fifo not flushed by tx reset");
	AST_LAST_CLEAR: assert property (tx_last_sent |=> !tx_last_byte_mark)
		else $error("last byte mark not cleared");
	AST_OE_CAUSE: assert property ($rose(bus_data_oe) |-> !$past(bus_rd_n, 2) && !$past(bus_cs_n, 2))
		else $error("data bus driven without a read");
	cover property (rx_engine_reset);
	cover property (!irq_n);
	cover property (tx_abort_request ##1 !tx_byte_valid);
	cover property (tx_last_sent);
endmodule

bind pls_port pls_port_properties u_props (.core_clk, .reset, .bus_cs_n, .bus_rd_n, .bus_data_oe, .irq_n,
	.rx_engine_reset, .tx_engine_reset, .tx_abort_request, .tx_fill_byte, .tx_last_byte_mark,
	.tx_byte_valid, .tx_last_sent);

// ==== dv/pls_engine_model.sv ====
// Transmit bit engine stand-in: takes FIFO bytes, reports last sent.
// Assumes the bench drives stall and slow just after the clock edge.
module pls_engine_model (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic stall,
	input wire logic slow,
	input wire logic tx_byte_valid,
	input wire logic [7:0] tx_byte_data,
	input wire logic tx_byte_last,
	output logic tx_byte_ready,
	output logic tx_last_sent,
	output int n_taken,
	output logic [7:0] last_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic phase_reg;
	// Slow mode takes a byte only every other cycle
	assign tx_byte_ready = !stall && (!slow || phase_reg);
	always_ff @(posedge core_clk) begin
		if (reset) begin
			phase_reg <= 1'b0;
			tx_last_sent <= 1'b0;
			n_taken <= 0;
			last_data <= 8'h00;
		end else begin
			phase_reg <= ~phase_reg;
			tx_last_sent <= 1'b0;
			if (tx_byte_valid && tx_byte_ready) begin
				n_taken <= n_taken + 1;
				last_data <= tx_byte_data;
				tx_last_sent <= tx_byte_last;
			end
		end
	end
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the packet link port through its host pins.
// Assumes the engine model stands on the transmit byte stream.
module testbench;
	import pls_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, reset = 1'b1, bus_cs_n = 1'b1, bus_rd_n = 1'b1, bus_wr_n = 1'b1;
	logic [7:0] bus_addr = 8'h00, host_d = 8'h00, rx_info = 8'h00;
	logic host_oe = 1'b0, stall = 1'b1, slow = 1'b0, rx_begin = 1'b0, rx_has = 1'b0, done_evt = 1'b0;
	logic rx_end = 1'b0, rx_half = 1'b0, underflow = 1'b0;
	// Event selectors for pulse
	localparam int P_UDR = 0, P_DONE = 1, P_END = 2, P_BEGIN = 3;
	logic [7:0] bus_data_out, bus_wire, last_data;
	logic bus_data_oe, irq_n, rx_rst, tx_rst, abort, last_mark, stuff_off, crc_off, valid, ready;
	logic [7:0] fill, tx_data;
	logic byte_last, last_sent;
	int n_mismatch = 0, cmp_count = 0, n_taken, n_rx = 0, n_tx = 0, n_ab = 0, k;
	// Pull-up on the shared data bus when nobody drives it
	assign bus_wire = bus_data_oe ? bus_data_out : (host_oe ? host_d : 8'hFF);
	`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
		$display("[ERR] %s exp %h got %h", nm, e, g); end end
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		n_rx += rx_rst;
		n_tx += tx_rst;
		n_ab += abort;
	end
	pls_port u_dut (.core_clk, .reset, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_addr, .bus_data_in(bus_wire),
		.bus_data_out, .bus_data_oe, .irq_n, .rx_engine_reset(rx_rst), .tx_engine_reset(tx_rst),
		.tx_abort_request(abort), .tx_fill_byte(fill), .tx_last_byte_mark(last_mark),
		.tx_bit_stuff_disable(stuff_off), .tx_checksum_disable(crc_off), .tx_byte_valid(valid),
		.tx_byte_ready(ready), .tx_byte_data(tx_data), .tx_byte_last(byte_last), .tx_last_sent(last_sent),
		.tx_frame_done_evt(done_evt), .tx_underflow_flag(underflow), .rx_frame_begin_evt(rx_begin),
		.rx_frame_finish_evt(rx_end), .rx_fifo_over_half(rx_half), .rx_fifo_has_data(rx_has), .rx_info);
	pls_engine_model u_eng (.core_clk, .reset, .stall, .slow, .tx_byte_valid(valid), .tx_byte_data(tx_data),
		.tx_byte_last(byte_last), .tx_byte_ready(ready), .tx_last_sent(last_sent), .n_taken, .last_data);
	// ----
	// Host access
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic stop_test;
		if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_addr = a;
		host_d = d;
		host_oe = 1'b1;
		bus_cs_n = 1'b0;
		bus_wr_n = 1'b0;
		tick(5);
		bus_wr_n = 1'b1;
		bus_cs_n = 1'b1;
		tick(4);
		host_oe = 1'b0;
		tick(5);
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		int i;
		bus_addr = a;
		bus_cs_n = 1'b0;
		bus_rd_n = 1'b0;
		for (i = 0; i < 20 && bus_data_oe !== 1'b1; i++) tick(1);
		if (i >= 20) begin
			n_mismatch++;
			stop_test();
		end
		tick(2);
		`CHK(nm, e, bus_wire)
		bus_rd_n = 1'b1;
		bus_cs_n = 1'b1;
		tick(8);
	endtask
	task automatic pulse(input int s);
		{rx_begin, rx_end, done_evt, underflow} = 4'(1 << s);
		tick(1);
		{rx_begin, rx_end, done_evt, underflow} = 4'h0;
		tick(1);
	endtask
	initial begin
		tick(2);
		reset = 1'b0;
		tick(1);
		rd_chk("ctrl", ADDR_CTRL, CTRL_RESET);
		rd_chk("mask", ADDR_IRQ_MASK, IRQ_MASK_RESET);
		rd_chk("unmapped", 8'hB7, 8'h00);
		rd_chk("status", ADDR_STATUS, 8'h06);
		rd_chk("txinfo", ADDR_TX_INFO, 8'h02);
		rx_info = 8'h05;
		rd_chk("rxinfo", ADDR_RX_INFO, 8'h05);
		wr(ADDR_CTRL, 8'h21);
		`CHK("fill", FILL_IDLE, fill)
		`CHK("crc", 1'b1, crc_off)
		`CHK("stuff", 1'b0, stuff_off)
		rd_chk("ctrl", ADDR_CTRL, 8'h21);
		wr(ADDR_CTRL, 8'h02);
		`CHK("fill", FILL_FLAG, fill)
		`CHK("crc", 1'b0, crc_off)
		`CHK("stuff", 1'b1, stuff_off)
		wr(ADDR_CTRL, 8'h50);
		wr(ADDR_CTRL, 8'h50);
		`CHK("rxrst", 1, n_rx)
		`CHK("txrst", 1, n_tx)
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h40);
		`CHK("rxrst", 2, n_rx)
		`CHK("txrst", 1, n_tx)
		wr(ADDR_CTRL, 8'h00);
		pulse(P_BEGIN);
		wr(ADDR_STATUS, 8'h20);
		rd_chk("latch", ADDR_STATUS, 8'h26);
		rd_chk("latch", ADDR_STATUS, 8'h26);
		wr(ADDR_STATUS, 8'h20);
		rd_chk("latch", ADDR_STATUS, 8'h06);
		rx_has = 1'b1;
		rx_half = 1'b1;
		wr(ADDR_STATUS, 8'h18);
		rd_chk("live", ADDR_STATUS, 8'h1E);
		rx_half = 1'b0;
		wr(ADDR_IRQ_MASK, 8'h08);
		`CHK("irq", 1'b0, irq_n)
		rx_has = 1'b0;
		tick(4);
		`CHK("irq", 1'b1, irq_n)
		wr(ADDR_IRQ_MASK, 8'h01);
		pulse(P_DONE);
		tick(3);
		`CHK("irq", 1'b0, irq_n)
		rd_chk("held", ADDR_STATUS, 8'h06);
		`CHK("irq", 1'b0, irq_n)
		wr(ADDR_STATUS, 8'h01);
		`CHK("irq", 1'b1, irq_n)
		rd_chk("copy", ADDR_STATUS, 8'h07);
		wr(ADDR_IRQ_MASK, 8'h00);
		pulse(P_DONE);
		tick(3);
		`CHK("irq", 1'b1, irq_n)
		// Receive handling: start interrupt, then data and end
		wr(ADDR_IRQ_MASK, 8'h20);
		pulse(P_BEGIN);
		tick(3);
		`CHK("irq", 1'b0, irq_n)
		wr(ADDR_STATUS, 8'h20);
		rd_chk("begin", ADDR_STATUS, 8'h27);
		wr(ADDR_STATUS, 8'h27 & 8'h20);
		rd_chk("begin", ADDR_STATUS, 8'h07);
		`CHK("irq", 1'b1, irq_n)
		wr(ADDR_IRQ_MASK, 8'h48);
		rx_has = 1'b1;
		rx_info = 8'h16;
		tick(1);
		rx_info = 8'h06;
		tick(3);
		`CHK("irq", 1'b0, irq_n)
		wr(ADDR_RX_INFO, 8'h10);
		rd_chk("rxinfo", ADDR_RX_INFO, 8'h16);
		rx_has = 1'b0;
		pulse(P_END);
		tick(3);
		`CHK("irq", 1'b0, irq_n)
		wr(ADDR_STATUS, 8'h40);
		`CHK("irq", 1'b1, irq_n)
		wr(ADDR_IRQ_MASK, 8'h20);
		rd_chk("mask", ADDR_IRQ_MASK, 8'h20);
		// Transmit handling
		wr(ADDR_STATUS, 8'h01);
		rd_chk("drained", ADDR_TX_INFO, 8'h02);
		wr(ADDR_IRQ_MASK, 8'h04);
		`CHK("irq", 1'b0, irq_n)
		for (k = 1; k < 16; k++) wr(ADDR_TX_DATA, 8'(k));
		wr(ADDR_CTRL, 8'h04);
		`CHK("lastmark", 1'b1, last_mark)
		wr(ADDR_TX_DATA, 8'h10);
		wr(ADDR_TX_DATA, 8'hAA);
		`CHK("irq", 1'b1, irq_n)
		rd_chk("full", ADDR_TX_INFO, 8'h01);
		slow = 1'b1;
		stall = 1'b0;
		for (k = 0; k < 200 && valid !== 1'b0; k++) tick(1);
		if (k >= 200) begin
			n_mismatch++;
			stop_test();
		end
		tick(3);
		`CHK("taken", 16, n_taken)
		`CHK("lastdata", 8'h10, last_data)
		`CHK("lastmark", 1'b0, last_mark)
		rd_chk("drained", ADDR_TX_INFO, 8'h02);
		wr(ADDR_IRQ_MASK, 8'h01);
		`CHK("irq", 1'b1, irq_n)
		pulse(P_DONE);
		pulse(P_UDR);
		tick(3);
		`CHK("irq", 1'b0, irq_n)
		wr(ADDR_TX_INFO, 8'h04);
		rd_chk("underflow", ADDR_TX_INFO, 8'h06);
		stall = 1'b1;
		for (k = 0; k < 3; k++) wr(ADDR_TX_DATA, 8'h7E);
		`CHK("valid", 1'b1, valid)
		wr(ADDR_CTRL, 8'h08);
		`CHK("abort", 1, n_ab)
		`CHK("flush", 1'b0, valid)
		stop_test();
	end
endmodule
